// >>> pdtx_pkg.sv
// constants, register map and types for the pd transmit launch block
`default_nettype none
package pdtx_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_CTL_A    = 16'h1a00;
  localparam logic [15:0] IDX_CTL_B    = 16'h1a05;
  localparam logic [15:0] IDX_PARAMS   = 16'h1a06;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h1a10;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h1a11;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTLA_RAW_BIT   = 0;
  localparam int CTLB_GO_BIT    = 0;
  localparam int CTLB_ABORT_BIT = 1;
  localparam int CTLB_HARD_BIT  = 2;
  localparam int CTLB_CABLE_BIT = 3;
  localparam int IRQ_EOP_BIT    = 0;
  localparam int IRQ_ABORT_BIT  = 1;
  localparam int IRQ_W          = 2;
  localparam int PRE_LEN_W      = 7;

  localparam logic [7:0] CTLA_RST     = 8'h00;
  localparam logic [7:0] PARAMS_RST   = 8'h20;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // ---------------------------------------------------------------
  // timing and symbols
  // ---------------------------------------------------------------
  localparam int CLK_KHZ       = 250000;
  localparam int BIT_RATE_KBPS = 300;
  localparam int BIT_CYCLES    = CLK_KHZ / BIT_RATE_KBPS;
  localparam int EOP_BITS      = 5;
  localparam logic [4:0] EOP_SYMBOL  = 5'h0d;
  localparam logic [3:0] HARD_NIBBLE  = 4'h7;
  localparam logic [3:0] CABLE_NIBBLE = 4'h3;
  localparam logic [2:0] RST_NIBBLES  = 3'h4;

  typedef enum logic [1:0] {
    PDTX_KIND_PKT,
    PDTX_KIND_HARD,
    PDTX_KIND_CABLE
  } pdtx_kind_t;

  // index to byte address
  function automatic logic [15:0] pdtx_addr(input logic [15:0] idx);
    pdtx_addr = {idx[13:0], 2'b00};
  endfunction

endpackage
`default_nettype wire

// >>> pdtx_bit_tick.sv
// bit-time enable divider for the line serializer
`timescale 1ns/1ns
`default_nettype none
module pdtx_bit_tick #(
  parameter int CYCLES = 833
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic run,
  output var  logic tick
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // held at zero while idle so the first bit gets a full period
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !run) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> pdtx_launch.sv
// pd transmit launch, abort and preamble control with apb registers
`timescale 1ns/1ns
`default_nettype none
module pdtx_launch
  import pdtx_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [3:0]  q_nibble,
  input  wire logic        q_last,
  output var  logic        q_pop,
  input  wire logic        collision_pin,
  output var  logic        tx_line,
  output var  logic        tx_drive,
  output var  logic        tx_end_of_packet_flag,
  output var  logic [1:0]  tx_kind,
  output var  logic        irq
);
  typedef enum logic [1:0] {S_IDLE, S_PRE, S_DATA, S_EOP} pdtx_state_t;

  pdtx_state_t             st_q;
  logic                    go_q, hard_q, cable_q, raw_q, abort_q, done_q;
  logic [PRE_LEN_W-1:0]    len_q, pre_len_q, bit_cnt_q;
  logic [IRQ_W-1:0]        stat_q, mask_q;
  logic [3:0]              nib_q;
  logic [1:0]              bit_idx_q;
  logic [2:0]              eop_idx_q, nib_cnt_q;
  logic                    last_q, coll1_q, coll2_q, coll3_q, coll_q;
  logic                    bit_en, wr, rd, start, ev_eop, ev_abort;
  logic                    hit_a, hit_b, hit_p, hit_s, hit_m;
  pdtx_kind_t              kind_q;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign wr    = psel && penable && pready && pwrite;
  assign rd    = psel && !penable && !pwrite;
  assign hit_a = paddr == pdtx_addr(IDX_CTL_A);
  assign hit_b = paddr == pdtx_addr(IDX_CTL_B);
  assign hit_p = paddr == pdtx_addr(IDX_PARAMS);
  assign hit_s = paddr == pdtx_addr(IDX_IRQ_STAT);
  assign hit_m = paddr == pdtx_addr(IDX_IRQ_MASK);
  assign start = st_q == S_IDLE && go_q && !done_q;

  // no wait state: answer prepared in setup, given in the first access cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(hit_a || hit_b || hit_p || hit_s || hit_m);
    end
  end

  // read mux, unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      if (hit_a) begin
        prdata <= {31'h0000_0000, raw_q};
      end else if (hit_b) begin
        prdata <= {28'h000_0000, cable_q, hard_q, 1'b0, go_q};
      end else if (hit_p) begin
        prdata <= {25'h000_0000, pre_len_q};
      end else if (hit_s) begin
        prdata <= {30'h0000_0000, stat_q};
      end else if (hit_m) begin
        prdata <= {30'h0000_0000, mask_q};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // go only set by software
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      go_q <= 1'b0;
    end else if (wr && hit_b && pwdata[CTLB_GO_BIT]) begin
      go_q <= 1'b1;
    end else if (done_q) begin
      go_q <= 1'b0;
    end
  end

  // reset requests: set only while go is clear, cleared at end
  always_ff @(posedge sys_clk) begin
    if (!rst_b || done_q) begin
      hard_q  <= 1'b0;
      cable_q <= 1'b0;
    end else if (wr && hit_b && !go_q) begin
      hard_q  <= hard_q | pwdata[CTLB_HARD_BIT];
      cable_q <= cable_q | pwdata[CTLB_CABLE_BIT];
    end
  end

  // plain read/write configuration
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      raw_q     <= CTLA_RST[CTLA_RAW_BIT];
      pre_len_q <= PARAMS_RST[PRE_LEN_W-1:0];
      mask_q    <= IRQ_MASK_RST;
    end else if (wr) begin
      if (hit_a) begin
        raw_q <= pwdata[CTLA_RAW_BIT];
      end else if (hit_p) begin
        // zero unchecked, software keeps to 1..127
        pre_len_q <= pwdata[PRE_LEN_W-1:0];
      end else if (hit_m) begin
        mask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // abort pending only while an attempt runs
  always_ff @(posedge sys_clk) begin
    if (!rst_b || st_q == S_IDLE) begin
      abort_q <= 1'b0;
    end else if (wr && hit_b && pwdata[CTLB_ABORT_BIT]) begin
      abort_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, set wins over write-one-to-clear
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_EOP_BIT && ev_eop) || (i == IRQ_ABORT_BIT && ev_abort)) begin
          stat_q[i] <= 1'b1;
        end else if (wr && hit_s && pwdata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      irq <= |(stat_q & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // collision input synchroniser
  // ---------------------------------------------------------------
  // accepted only when the last two stages agree, filters a metastable edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      coll1_q <= 1'b0;
      coll2_q <= 1'b0;
      coll3_q <= 1'b0;
      coll_q  <= 1'b0;
    end else begin
      coll1_q <= collision_pin;
      coll2_q <= coll1_q;
      coll3_q <= coll2_q;
      if (coll2_q == coll3_q) begin
        coll_q <= coll3_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // serializer
  // ---------------------------------------------------------------
  pdtx_bit_tick #(
    .CYCLES (BIT_CYC)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (st_q != S_IDLE),
    .tick    (bit_en)
  );

  assign ev_abort = coll_q && st_q != S_IDLE;
  assign ev_eop   = bit_en && !ev_abort
                    && ((st_q == S_PRE && abort_q)
                        || (st_q == S_EOP && eop_idx_q == 3'(EOP_BITS - 1)));

  // main sequencer; collision takes priority over every bit step
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      {tx_line, tx_drive, tx_end_of_packet_flag, q_pop, done_q, last_q} <= 6'h00;
      tx_kind <= PDTX_KIND_PKT;
      kind_q <= PDTX_KIND_PKT;
      {len_q, bit_cnt_q} <= 14'h0000;
      {nib_q, bit_idx_q, eop_idx_q, nib_cnt_q} <= 12'h000;
    end else begin
      q_pop  <= 1'b0;
      done_q <= 1'b0;
      if (ev_abort) begin
        st_q     <= S_IDLE;
        tx_drive <= 1'b0;
        tx_line  <= 1'b0;
        tx_end_of_packet_flag   <= 1'b0;
        done_q   <= 1'b1;
      end else if (start) begin
        // launch; reset kinds only in auto mode
        st_q      <= S_PRE;
        kind_q    <= raw_q ? PDTX_KIND_PKT : hard_q ? PDTX_KIND_HARD
                   : cable_q ? PDTX_KIND_CABLE : PDTX_KIND_PKT;
        tx_kind   <= raw_q ? PDTX_KIND_PKT : hard_q ? PDTX_KIND_HARD
                   : cable_q ? PDTX_KIND_CABLE : PDTX_KIND_PKT;
        len_q     <= pre_len_q;
        bit_cnt_q <= '0;
        tx_line   <= 1'b0;
        tx_drive  <= 1'b1;
      end else if (bit_en) begin
        case (st_q)
          S_PRE: begin
            if (abort_q) begin
              st_q     <= S_IDLE;
              tx_drive <= 1'b0;
              tx_line  <= 1'b0;
              done_q   <= 1'b1;
            end else if (bit_cnt_q == len_q - 1'b1) begin
              st_q      <= S_DATA;
              bit_idx_q <= 2'h0;
              nib_cnt_q <= 3'h0;
              if (kind_q == PDTX_KIND_PKT) begin
                nib_q   <= q_nibble;
                tx_line <= q_nibble[0];
                last_q  <= q_last;
                q_pop   <= 1'b1;
              end else begin
                nib_q   <= kind_q == PDTX_KIND_HARD ? HARD_NIBBLE : CABLE_NIBBLE;
                tx_line <= kind_q == PDTX_KIND_HARD ? HARD_NIBBLE[0] : CABLE_NIBBLE[0];
                last_q  <= 1'b0;
              end
            end else begin
              bit_cnt_q <= bit_cnt_q + 1'b1;
              tx_line   <= ~tx_line;
            end
          end
          S_DATA: begin
            if (bit_idx_q != 2'h3) begin
              bit_idx_q <= bit_idx_q + 1'b1;
              tx_line   <= nib_q[bit_idx_q + 2'h1];
            end else if (abort_q || last_q) begin
              // nibble complete, append end of packet
              st_q      <= S_EOP;
              eop_idx_q <= 3'h0;
              tx_line   <= EOP_SYMBOL[0];
              tx_end_of_packet_flag    <= 1'b1;
            end else begin
              bit_idx_q <= 2'h0;
              nib_cnt_q <= nib_cnt_q + 1'b1;
              if (kind_q == PDTX_KIND_PKT) begin
                nib_q   <= q_nibble;
                tx_line <= q_nibble[0];
                last_q  <= q_last;
                q_pop   <= 1'b1;
              end else begin
                tx_line <= nib_q[0];
                last_q  <= nib_cnt_q == RST_NIBBLES - 3'h2;
              end
            end
          end
          S_EOP: begin
            if (eop_idx_q == 3'(EOP_BITS - 1)) begin
              // end of attempt only, no delivery claim
              st_q     <= S_IDLE;
              tx_drive <= 1'b0;
              tx_line  <= 1'b0;
              tx_end_of_packet_flag   <= 1'b0;
              done_q   <= 1'b1;
            end else begin
              eop_idx_q <= eop_idx_q + 1'b1;
              tx_line   <= EOP_SYMBOL[eop_idx_q + 3'h1];
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // go holds until hardware ends the attempt
  go_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go_q && !done_q |=> go_q) else $error("go dropped without end of attempt");
  go_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done_q && !(wr && hit_b) |=> !go_q) else $error("go not cleared at end");
  abort_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd && hit_b |=> !prdata[CTLB_ABORT_BIT]) else $error("abort bit read as one");
  pre_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start |=> st_q == S_PRE && !tx_line && tx_drive) else $error("preamble start wrong");
  pre_alt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_q == S_PRE |-> tx_line == bit_cnt_q[0]) else $error("preamble not alternating");
  pre_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_q == S_PRE && bit_en && !ev_abort && !abort_q && bit_cnt_q == len_q - 1'b1
    |=> st_q == S_DATA) else $error("preamble length wrong");
  // abort in preamble stops after the bit
  abort_pre_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_q == S_PRE && bit_en && abort_q |=> st_q == S_IDLE && !tx_drive)
    else $error("abort in preamble not honoured");
  // abort at nibble end goes to end of packet
  abort_nib_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_q == S_DATA && bit_en && !ev_abort && bit_idx_q == 2'h3 && abort_q
    |=> st_q == S_EOP && tx_end_of_packet_flag) else $error("abort skipped end of packet");
  // collision aborts and flags within two cycles
  coll_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ev_abort |=> st_q == S_IDLE ##1 stat_q[IRQ_ABORT_BIT]) else $error("collision not handled");
  // hard reset chosen in auto mode
  hard_kind_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start && hard_q && !raw_q |=> tx_kind == PDTX_KIND_HARD) else $error("hard reset not sent");
endmodule
`default_nettype wire

// >>> pdtx_far_port.sv
// far-end port model: samples the line bits and drives the collision pin
`timescale 1ns/1ns
`default_nettype none
module pdtx_far_port #(
  parameter int BIT_CYC = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         tx_line,
  input  wire logic         tx_drive,
  input  wire logic         tx_end_of_packet_flag,
  input  wire logic         clash,
  output var  logic         collision_pin,
  output var  logic [255:0] rx_bits,
  output var  int           rx_n,
  output var  int           eop_n
);
  int cnt;

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  // sample mid-bit so edge placement inside a bit does not matter
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !tx_drive) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
      if (cnt == 0) begin
        rx_n  <= 0;
        eop_n <= 0;
      end else begin
        if (cnt % BIT_CYC == BIT_CYC / 2) begin
          rx_bits[rx_n[7:0]] <= tx_line;
          rx_n               <= rx_n + 1;
        end
        if (tx_end_of_packet_flag) begin
          eop_n <= eop_n + 1;
        end
      end
    end
  end

  // collision only when the bench asks for one
  always_comb collision_pin = clash;
endmodule
`default_nettype wire

// >>> pdtx_launch_bench.sv
// self-checking bench for the pd transmit launch block
`timescale 1ns/1ns
`default_nettype none
module pdtx_launch_bench
  import pdtx_pkg::*;
;
  localparam int          B      = 4;
  localparam logic [15:0] A_CTLA = IDX_CTL_A << 2;
  localparam logic [15:0] A_CTLB = IDX_CTL_B << 2;
  localparam logic [15:0] A_PAR  = IDX_PARAMS << 2;
  localparam logic [15:0] A_STAT = IDX_IRQ_STAT << 2;
  localparam logic [15:0] A_MASK = IDX_IRQ_MASK << 2;
  logic         sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, er_v;
  logic         q_last, q_pop, collision_pin, tx_line, tx_drive, tx_end_of_packet_flag, irq, clash;
  logic [15:0]  paddr;
  logic [31:0]  pwdata, prdata, rd_v;
  logic [3:0]   q_nibble;
  logic [1:0]   tx_kind;
  logic [255:0] rx_bits;
  logic [3:0]   qn [0:7];
  int           rx_n, eop_n, err_total, comparisons, qp, qlen, k;

  pdtx_launch #(.BIT_CYC(B)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .q_nibble(q_nibble), .q_last(q_last), .q_pop(q_pop),
    .collision_pin(collision_pin), .tx_line(tx_line), .tx_drive(tx_drive), .tx_end_of_packet_flag(tx_end_of_packet_flag),
    .tx_kind(tx_kind), .irq(irq));
  pdtx_far_port #(.BIT_CYC(B)) far (.sys_clk(sys_clk), .rst_b(rst_b), .tx_line(tx_line),
    .tx_drive(tx_drive), .tx_end_of_packet_flag(tx_end_of_packet_flag), .clash(clash), .collision_pin(collision_pin),
    .rx_bits(rx_bits), .rx_n(rx_n), .eop_n(eop_n));

  // ---------------------------------------------------------------
  // clock and transmit queue feeder
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // next nibble is presented at the pop edge, well before the next load
  always @(posedge sys_clk) begin
    if (q_pop === 1'b1) begin
      qp       <= qp + 1;
      q_nibble <= qn[(qp + 1) % 8];
      q_last   <= (qp + 1 == qlen - 1);
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, msg, got, exp);
    end
  endtask

  task automatic hang(input string msg);
    err_total++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    conclude();
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang("apb ready");
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_v, exp, msg);
  endtask

  // poll go until the attempt has ended
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, A_CTLB, 32'h0000_0000);
      n++;
    end while (rd_v[0] !== 1'b0 && n < 300);
    if (rd_v[0] !== 1'b0) hang("go clear");
  endtask

  // the far count of the last frame stands until the new drive has been seen,
  // so wait for drive and the count restart before trusting it
  task automatic wait_bits(input int m);
    int n;
    n = 0;
    while (tx_drive !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
    while (rx_n < m && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (rx_n < m || n >= 3000) hang("line bits");
  endtask

  task automatic launch(input int pre, input int len, input logic [31:0] raw);
    apb(1'b1, A_PAR, pre);
    apb(1'b1, A_CTLA, raw);
    qlen = len;
    @(posedge sys_clk);
    qp       <= 0;
    q_nibble <= qn[0];
    q_last   <= (len == 1);
  endtask

  // expected frame: alternating preamble from zero, nibbles lsb first, end symbol
  task automatic frame_check(input int pre, input int nn, input int kind);
    logic [255:0] e;
    logic [3:0]   nib;
    int           n, bad;
    n = 0;
    bad = 0;
    for (int i = 0; i < pre; i++) begin
      e[n] = i[0];
      n++;
    end
    for (int j = 0; j < nn; j++) begin
      nib = (kind == 1) ? HARD_NIBBLE : (kind == 2) ? CABLE_NIBBLE : qn[j];
      for (int b = 0; b < 4; b++) begin
        e[n] = nib[b];
        n++;
      end
    end
    for (int b = 0; b < EOP_BITS; b++) begin
      e[n] = EOP_SYMBOL[b];
      n++;
    end
    for (int i = 0; i < n; i++) bad += (rx_bits[i] !== e[i]);
    chk(rx_n, n, "frame length");
    chk(bad, 0, "frame bits");
    chk(eop_n, EOP_BITS * B, "end marker cycles");
  endtask

  task automatic send(input int pre, input int len, input logic [31:0] req,
                      input logic [31:0] raw, input int kind);
    launch(pre, len, raw);
    rd(A_PAR, pre, "preamble length");
    if (req != 0) apb(1'b1, A_CTLB, req);
    apb(1'b1, A_CTLB, 32'h0000_0001);
    apb(1'b1, A_CTLB, 32'h0000_0000);
    apb(1'b0, A_CTLB, 32'h0000_0000);
    chk(rd_v[0], 1'b1, "go kept after zero write");
    wait_bits(1);
    chk(tx_kind, kind, "frame kind");
    wait_idle();
    chk(rd_v, 32'h0000_0000, "control after attempt");
    frame_check(pre, (kind == 0) ? len : RST_NIBBLES, kind);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, clash, q_last} = '0;
    q_nibble = 4'h0;
    qn = '{4'h5, 4'ha, 4'h3, 4'hc, 4'h9, 4'h6, 4'h1, 4'he};
    {err_total, comparisons, qp, qlen} = '0;
    rst_b = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(A_PAR, {24'h0, PARAMS_RST}, "params reset");
    rd(A_CTLA, 32'h0000_0000, "control a reset");
    rd(A_CTLB, 32'h0000_0000, "control b reset");
    rd(A_STAT, 32'h0000_0000, "status reset");
    rd(A_MASK, 32'h0000_0000, "mask reset");
    rd(16'h7000, 32'h0000_0000, "unmapped read");
    chk(er_v, 1'b1, "unmapped error");
    send(4, 2, 32'h0, 32'h0, 0);
    rd(A_STAT, 32'h0000_0001, "end flag set");
    apb(1'b1, A_STAT, 32'h0000_0001);
    rd(A_STAT, 32'h0000_0000, "end flag cleared");
    send(5, 1, 32'h0, 32'h0, 0);
    send(64, 3, 32'h0, 32'h0, 0);
    send(4, 2, 32'h4, 32'h0, 1);
    send(4, 2, 32'h8, 32'h0, 2);
    send(6, 2, 32'h4, 32'h1, 0);
    // abort in the data phase
    launch(4, 4, 32'h0);
    apb(1'b1, A_CTLB, 32'h0000_0001);
    wait_bits(4 + 5);
    apb(1'b1, A_CTLB, 32'h0000_0002);
    apb(1'b0, A_CTLB, 32'h0000_0000);
    chk(rd_v[1], 1'b0, "abort reads zero");
    wait_idle();
    k = (rx_n - 4 - EOP_BITS) / 4;
    chk(k < 4, 1'b1, "abort cut frame short");
    frame_check(4, k, 0);
    apb(1'b1, A_STAT, 32'h0000_0003);
    // abort in the preamble
    launch(20, 2, 32'h0);
    apb(1'b1, A_CTLB, 32'h0000_0001);
    wait_bits(3);
    apb(1'b1, A_CTLB, 32'h0000_0002);
    wait_idle();
    chk(rx_n < 8, 1'b1, "preamble cut short");
    chk(rx_bits[3:0], 4'b1010, "preamble bits");
    chk(eop_n, 0, "no end marker");
    rd(A_STAT, 32'h0000_0001, "end flag after preamble abort");
    apb(1'b1, A_STAT, 32'h0000_0003);
    // collision, interrupt mask and clear
    apb(1'b1, A_MASK, 32'h0000_0002);
    launch(4, 4, 32'h0);
    apb(1'b1, A_CTLB, 32'h0000_0001);
    wait_bits(6);
    clash <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (tx_drive !== 1'b0 && k < 12);
    chk(tx_drive, 1'b0, "drive off on collision");
    clash <= 1'b0;
    wait_idle();
    rd(A_STAT, 32'h0000_0002, "aborted flag");
    chk(irq, 1'b1, "interrupt raised");
    apb(1'b1, A_MASK, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0, "interrupt masked");
    apb(1'b1, A_MASK, 32'h0000_0002);
    apb(1'b1, A_STAT, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0, "interrupt cleared");
    rd(A_STAT, 32'h0000_0000, "status cleared");
    // block reset in mid-frame drops drive and go, restores defaults
    launch(4, 2, 32'h0);
    apb(1'b1, A_CTLB, 32'h0000_0001);
    wait_bits(2);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    chk(tx_drive, 1'b0, "drive off in reset");
    rd(A_CTLB, 32'h0000_0000, "go cleared by reset");
    rd(A_PAR, {24'h0, PARAMS_RST}, "params after reset");
    apb(1'b1, 16'h7004, 32'hffff_ffff);
    chk(er_v, 1'b1, "unmapped write error");
    conclude();
  end
endmodule
`default_nettype wire
